// File: i2c_id_regs.svh
// Reset values, CRC constants and bus setup field positions
`ifndef I2C_ID_REGS_SVH
`define I2C_ID_REGS_SVH
`define CRC_POLY 8'h07
`define CRC_INIT 8'hFF
`define CRC_EN_BIT 0
`define BUS_SETUP_RST 16'h0001
`define GAIN_RST 8'h00
`define ENABLE_RST 16'h0000
`define RATE_RST 8'h00
`define SETTING_A_RST 16'h0000
`define SETTING_B_RST 16'h0000
`define FUSE_ADDR_RST 8'h00
`endif

// File: i2c_id_pkg.sv
// Command codes, state codes and the decoder state record
package i2c_id_pkg;
  typedef enum logic [7:0] {
    cmd_write_bus_setup = 8'h00,
    cmd_write_dimming = 8'h01,
    cmd_write_everything = 8'h02,
    cmd_write_dimming_rate = 8'h03,
    cmd_read_bus_state = 8'h08,
    cmd_read_failures = 8'h09,
    cmd_read_everything = 8'h0A,
    cmd_program_fuses = 8'h20,
    cmd_program_and_lock_fuses = 8'h21,
    cmd_read_fuses = 8'h28
  } cmd_t;

  typedef enum logic [6:0] {
    st_idle = 7'h01,
    st_addr = 7'h02,
    st_ack = 7'h04,
    st_rx = 7'h08,
    st_tx = 7'h10,
    st_tx_ack = 7'h20,
    st_ignore = 7'h40
  } state_t;

  typedef struct packed {
    state_t state;
    logic scl_prev;
    logic sda_prev;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic rw;
    logic [7:0] cmd;
    logic [3:0] idx;
    logic [39:0] wbuf;
    logic [7:0] crc;
    logic crc_ok;
    logic [7:0] tx_byte;
    logic sda_oe;
    logic sda_out;
    logic [15:0] bus_setup;
    logic [7:0] gain;
    logic [15:0] enables;
    logic [7:0] rate;
    logic [15:0] sa;
    logic [15:0] sb;
    logic [7:0] faddr;
    logic locked;
    logic [15:0] active;
    logic crc_err;
  } core_t;
endpackage

// File: bit_sync.sv
// Two-flop synchroniser for a group of independent levels
`timescale 1ns/1ps
module bit_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST = '0
) (
  input wire logic clk_i, // Destination clock
  input wire logic resetn_i, // Synchronous reset, active low
  input wire logic [WIDTH-1:0] d_i, // Asynchronous levels
  output logic [WIDTH-1:0] q_o // Synchronised levels
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_t;
  sync_t s_reg;
  sync_t s_next;

  always_comb begin
    s_next.meta = d_i;
    s_next.stable = s_reg.meta;
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      s_reg <= {RST, RST};
    end else begin
      s_reg <= s_next;
    end
  end

  assign q_o = s_reg.stable;
endmodule

// File: link_bit_capture.sv
// Data line sampled on each rising edge of the bus clock
`timescale 1ns/1ps
module link_bit_capture (
  input wire logic scl_i, // Bus clock from the master
  input wire logic sda_i, // Data line level
  output logic bit_o // Bit taken at the last rising edge
);
  typedef struct packed {
    logic data;
  } link_t;
  link_t l_reg;
  link_t l_next;

  // Held for a whole bus clock period, long past the core's edge latency
  always_comb begin
    l_next.data = sda_i;
  end

  always_ff @(posedge scl_i) begin
    l_reg <= l_next;
  end

  assign bit_o = l_reg.data;
endmodule

// File: i2c_id_command_decoder.sv
// Bus slave, identifier decode and register file of the LED driver
`timescale 1ns/1ps
`include "i2c_id_regs.svh"
// Functional notes
// - Slave only; master makes clock, start, stop
// - Frames in both directions carry CRC8
// - Identifier byte selects layout, direction, registers
// - Codes 00, 03 write single registers; 01 writes gain, enables
// - Code 02 writes setup, gain, enables together
// - Codes 08, 09 return status and failures
// - Codes 20, 21 program fuses; 21 locks
// - Code 28 returns versions, settings, address
// - CRC byte omitted when protection disabled
// - Fixed, fuse and volatile register classes
// - Bus bit rates up to 400 kb/s
// - Fuse programming only with select high
// - Select input low picks setting A
module i2c_id_command_decoder #(
  parameter logic [6:0] SLAVE_ADDR = 7'h3A, // Bus address
  parameter logic [7:0] VERSION_A = 8'h5A, // Arbitrary value
  parameter logic [7:0] VERSION_B = 8'hA5 // Arbitrary value
) (
  input wire logic core_clk_i, // Core clock, 250 MHz
  input wire logic resetn_i, // Synchronous reset, active low
  input wire logic scl_i, // Bus clock pin
  input wire logic sda_i, // Data pin level
  output logic sda_o, // Data pin drive level, always low
  output logic sda_oe_o, // Data pin pulled low while high
  input wire logic fuse_program_select_i, // Fuse programming allowed
  input wire logic setting_select_input_i, // Standalone setting pick
  input wire logic [7:0] bus_state_i, // Bus status value
  input wire logic [15:0] failures_i, // Failure flags
  input wire logic [15:0] channel_state_i, // Channel status
  output logic [15:0] bus_setup_o, // Bus configuration
  output logic [7:0] dimming_gain_o, // Dimming gain
  output logic [15:0] dimming_enable_o, // Channel dimming enables
  output logic [7:0] dimming_rate_o, // Dimming frequency setting
  output logic [15:0] standalone_a_o, // Standalone setting A
  output logic [15:0] standalone_b_o, // Standalone setting B
  output logic [7:0] fuse_address_o, // Fuse address setting
  output logic fuses_locked_o, // Fuse words locked
  output logic [15:0] active_setting_o, // Selected standalone word
  output logic crc_error_o // Pulse: write frame CRC mismatch
);
  localparam i2c_id_pkg::core_t CORE_RST = '{
    state: i2c_id_pkg::st_idle,
    scl_prev: 1'b1,
    sda_prev: 1'b1,
    crc: `CRC_INIT,
    bus_setup: `BUS_SETUP_RST,
    gain: `GAIN_RST,
    enables: `ENABLE_RST,
    rate: `RATE_RST,
    sa: `SETTING_A_RST,
    sb: `SETTING_B_RST,
    faddr: `FUSE_ADDR_RST,
    default: '0
  };

  i2c_id_pkg::core_t r_reg;
  i2c_id_pkg::core_t r_next;
  logic [3:0] sync_q;
  logic scl_s, sda_s, fsel_s, sel_s, link_bit;
  logic start, stop, scl_rise, scl_fall, crc_en, write_done;
  logic [3:0] wl, rl;
  logic [55:0] rdata, rsh;
  logic [7:0] tx_pick, tx_sh;

  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++) begin
      x = x[7] ? ((x << 1) ^ `CRC_POLY) : (x << 1);
    end
    return x;
  endfunction

  // Data bytes a write command carries
  function automatic logic [3:0] wlen(input logic [7:0] c);
    case (c)
      i2c_id_pkg::cmd_write_bus_setup: wlen = 4'h2;
      i2c_id_pkg::cmd_write_dimming: wlen = 4'h3;
      i2c_id_pkg::cmd_write_everything: wlen = 4'h5;
      i2c_id_pkg::cmd_write_dimming_rate: wlen = 4'h1;
      i2c_id_pkg::cmd_program_fuses,
      i2c_id_pkg::cmd_program_and_lock_fuses: wlen = 4'h5;
      default: wlen = 4'h0;
    endcase
  endfunction

  // Data bytes a read command returns
  function automatic logic [3:0] rlen(input logic [7:0] c);
    case (c)
      i2c_id_pkg::cmd_read_bus_state: rlen = 4'h1;
      i2c_id_pkg::cmd_read_failures: rlen = 4'h2;
      i2c_id_pkg::cmd_read_everything: rlen = 4'h5;
      i2c_id_pkg::cmd_read_fuses: rlen = 4'h7;
      default: rlen = 4'h0;
    endcase
  endfunction

  // Pins pass two flops; 250 MHz sampling leaves wide margin at 400 kb/s
  bit_sync #(.WIDTH(4), .RST(4'h3)) pin_sync (
    .clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .d_i({setting_select_input_i, fuse_program_select_i, sda_i, scl_i}),
    .q_o(sync_q)
  );

  link_bit_capture link_cap (
    .scl_i(scl_i),
    .sda_i(sda_i),
    .bit_o(link_bit)
  );

  assign scl_s = sync_q[0];
  assign sda_s = sync_q[1];
  assign fsel_s = sync_q[2];
  assign sel_s = sync_q[3];
  // Start and stop are data edges while the master holds clock high
  assign start = r_reg.scl_prev & scl_s & r_reg.sda_prev & ~sda_s;
  assign stop = r_reg.scl_prev & scl_s & ~r_reg.sda_prev & sda_s;
  assign scl_rise = ~r_reg.scl_prev & scl_s;
  assign scl_fall = r_reg.scl_prev & ~scl_s;
  assign crc_en = r_reg.bus_setup[`CRC_EN_BIT];
  assign wl = wlen(r_reg.cmd);
  assign rl = rlen(r_reg.cmd);
  assign write_done = ~r_reg.rw && (wl != 4'h0)
    && (r_reg.idx == 4'(wl + 4'h1 + {3'b000, crc_en}))
    && (~crc_en || r_reg.crc_ok);

  // Read payload, first byte in the top bits
  always_comb begin
    case (r_reg.cmd)
      i2c_id_pkg::cmd_read_bus_state:
        rdata = {bus_state_i, 48'h0};
      i2c_id_pkg::cmd_read_failures:
        rdata = {failures_i, 40'h0};
      i2c_id_pkg::cmd_read_everything:
        rdata = {channel_state_i, bus_state_i, failures_i, 16'h0};
      i2c_id_pkg::cmd_read_fuses:
        rdata = {VERSION_A, VERSION_B, r_reg.sa, r_reg.sb,
                 r_reg.faddr};
      default:
        rdata = 56'h0;
    endcase
    rsh = rdata << {r_reg.idx, 3'b000};
    if (r_reg.idx < rl) begin
      tx_pick = rsh[55:48];
    end else if (r_reg.idx == rl && crc_en) begin
      tx_pick = r_reg.crc;
    end else begin
      tx_pick = 8'hFF;
    end
    tx_sh = r_reg.tx_byte << r_reg.bit_cnt[2:0];
  end

  always_comb begin
    r_next = r_reg;
    r_next.crc_err = 1'b0;
    r_next.scl_prev = scl_s;
    r_next.sda_prev = sda_s;
    r_next.active = sel_s ? r_reg.sb : r_reg.sa;
    if (start) begin
      r_next.state = i2c_id_pkg::st_addr;
      r_next.bit_cnt = 4'h0;
      r_next.idx = 4'h0;
      r_next.crc = `CRC_INIT;
      r_next.crc_ok = 1'b0;
      r_next.sda_oe = 1'b0;
    end else if (stop) begin
      r_next.state = i2c_id_pkg::st_idle;
      r_next.sda_oe = 1'b0;
      if (write_done) begin
        case (r_reg.cmd)
          i2c_id_pkg::cmd_write_bus_setup: begin
            r_next.bus_setup = r_reg.wbuf[15:0];
          end
          i2c_id_pkg::cmd_write_dimming: begin
            r_next.gain = r_reg.wbuf[23:16];
            r_next.enables = r_reg.wbuf[15:0];
          end
          i2c_id_pkg::cmd_write_everything: begin
            r_next.bus_setup = r_reg.wbuf[39:24];
            r_next.gain = r_reg.wbuf[23:16];
            r_next.enables = r_reg.wbuf[15:0];
          end
          i2c_id_pkg::cmd_write_dimming_rate: begin
            r_next.rate = r_reg.wbuf[7:0];
          end
          i2c_id_pkg::cmd_program_fuses,
          i2c_id_pkg::cmd_program_and_lock_fuses: begin
            if (fsel_s && !r_reg.locked) begin
              r_next.sa = r_reg.wbuf[39:24];
              r_next.sb = r_reg.wbuf[23:8];
              r_next.faddr = r_reg.wbuf[7:0];
              r_next.locked = (r_reg.cmd ==
                i2c_id_pkg::cmd_program_and_lock_fuses);
            end
          end
          default: begin
          end
        endcase
      end else if (~r_reg.rw && crc_en && wl != 4'h0
                   && r_reg.idx == 4'(wl + 4'h2) && !r_reg.crc_ok) begin
        r_next.crc_err = 1'b1;
      end
    end else if (scl_rise) begin
      if (r_reg.state == i2c_id_pkg::st_addr
          || r_reg.state == i2c_id_pkg::st_rx) begin
        r_next.shift = {r_reg.shift[6:0], link_bit};
        r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
      end else if (r_reg.state == i2c_id_pkg::st_tx_ack && link_bit) begin
        r_next.state = i2c_id_pkg::st_ignore;
      end
    end else if (scl_fall) begin
      unique case (r_reg.state)
        i2c_id_pkg::st_idle, i2c_id_pkg::st_ignore: begin
        end
        i2c_id_pkg::st_addr: begin
          if (r_reg.bit_cnt == 4'h8) begin
            if (r_reg.shift[7:1] == SLAVE_ADDR) begin
              r_next.state = i2c_id_pkg::st_ack;
              r_next.sda_oe = 1'b1;
              r_next.rw = r_reg.shift[0];
            end else begin
              r_next.state = i2c_id_pkg::st_ignore;
            end
          end
        end
        i2c_id_pkg::st_rx: begin
          if (r_reg.bit_cnt == 4'h8) begin
            r_next.state = i2c_id_pkg::st_ack;
            r_next.sda_oe = 1'b1;
            r_next.idx = (r_reg.idx == 4'hF) ? r_reg.idx : r_reg.idx + 4'h1;
            if (r_reg.idx == 4'h0) begin
              // Unknown identifier is refused with a missing ack
              if (wlen(r_reg.shift) == 4'h0
                  && rlen(r_reg.shift) == 4'h0) begin
                r_next.state = i2c_id_pkg::st_ignore;
                r_next.sda_oe = 1'b0;
              end
              r_next.cmd = r_reg.shift;
              r_next.crc = crc8(r_reg.crc, r_reg.shift);
            end else if (r_reg.idx <= wl) begin
              r_next.wbuf = {r_reg.wbuf[31:0], r_reg.shift};
              r_next.crc = crc8(r_reg.crc, r_reg.shift);
            end else if (r_reg.idx == 4'(wl + 4'h1)) begin
              r_next.crc_ok = (r_reg.shift == r_reg.crc);
            end
          end
        end
        i2c_id_pkg::st_ack, i2c_id_pkg::st_tx_ack: begin
          if (r_reg.state == i2c_id_pkg::st_ack && !r_reg.rw) begin
            r_next.state = i2c_id_pkg::st_rx;
            r_next.sda_oe = 1'b0;
            r_next.bit_cnt = 4'h0;
          end else begin
            r_next.state = i2c_id_pkg::st_tx;
            r_next.tx_byte = tx_pick;
            r_next.sda_oe = ~tx_pick[7];
            r_next.bit_cnt = 4'h1;
            r_next.idx = (r_reg.idx == 4'hF) ? r_reg.idx : r_reg.idx + 4'h1;
            if (r_reg.idx < rl) begin
              r_next.crc = crc8(r_reg.crc, tx_pick);
            end
          end
        end
        i2c_id_pkg::st_tx: begin
          if (r_reg.bit_cnt == 4'h8) begin
            r_next.state = i2c_id_pkg::st_tx_ack;
            r_next.sda_oe = 1'b0;
          end else begin
            r_next.sda_oe = ~tx_sh[7];
            r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      r_reg <= CORE_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign sda_o = r_reg.sda_out;
  assign sda_oe_o = r_reg.sda_oe;
  assign bus_setup_o = r_reg.bus_setup;
  assign dimming_gain_o = r_reg.gain;
  assign dimming_enable_o = r_reg.enables;
  assign dimming_rate_o = r_reg.rate;
  assign standalone_a_o = r_reg.sa;
  assign standalone_b_o = r_reg.sb;
  assign fuse_address_o = r_reg.faddr;
  assign fuses_locked_o = r_reg.locked;
  assign active_setting_o = r_reg.active;
  assign crc_error_o = r_reg.crc_err;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  idle_release_a: assert property (
    r_reg.state == i2c_id_pkg::st_idle |-> !sda_oe_o && !sda_o)
    else $error("data line driven while idle");
  addr_ack_a: assert property (
    r_reg.state == i2c_id_pkg::st_addr && scl_fall
    && r_reg.bit_cnt == 4'h8 && r_reg.shift[7:1] == SLAVE_ADDR
    |=> sda_oe_o && r_reg.state == i2c_id_pkg::st_ack)
    else $error("own address not acknowledged");
  bad_id_nack_a: assert property (
    r_reg.state == i2c_id_pkg::st_rx && scl_fall && r_reg.bit_cnt == 4'h8
    && r_reg.idx == 4'h0 && wlen(r_reg.shift) == 4'h0
    && rlen(r_reg.shift) == 4'h0
    |=> !sda_oe_o && r_reg.state == i2c_id_pkg::st_ignore)
    else $error("unknown identifier acknowledged");
  setup_write_a: assert property (
    stop && write_done && r_reg.cmd == i2c_id_pkg::cmd_write_bus_setup
    |=> bus_setup_o == r_reg.wbuf[15:0])
    else $error("bus setup not written");
  write_all_a: assert property (
    stop && write_done && r_reg.cmd == i2c_id_pkg::cmd_write_everything
    |=> bus_setup_o == r_reg.wbuf[39:24]
    && dimming_gain_o == r_reg.wbuf[23:16]
    && dimming_enable_o == r_reg.wbuf[15:0])
    else $error("write-all not applied");
  crc_bad_keep_a: assert property (
    stop && crc_en && !r_reg.rw && !r_reg.crc_ok
    |=> $stable(bus_setup_o) && $stable(dimming_enable_o)
    && $stable(standalone_a_o))
    else $error("registers changed on bad CRC");
  crc_flag_a: assert property (
    stop && !r_reg.rw && crc_en && wl != 4'h0 && !r_reg.crc_ok
    && r_reg.idx == 4'(wl + 4'h2) |=> crc_error_o ##1 !crc_error_o)
    else $error("CRC mismatch not flagged");
  fuse_block_a: assert property (
    !fsel_s |=> $stable(standalone_a_o) && $stable(fuse_address_o))
    else $error("fuses changed without select");
  lock_hold_a: assert property (
    fuses_locked_o |=> fuses_locked_o && $stable(standalone_b_o))
    else $error("locked fuses changed");
  setting_pick_a: assert property (
    1'b1 |=> active_setting_o == ($past(sel_s) ? $past(standalone_b_o)
                                               : $past(standalone_a_o)))
    else $error("wrong standalone setting selected");
  tx_first_bit_a: assert property (
    r_reg.state == i2c_id_pkg::st_ack && r_reg.rw && scl_fall
    |=> r_reg.state == i2c_id_pkg::st_tx && sda_oe_o != r_reg.tx_byte[7])
    else $error("first read bit not driven");
  tx_release_a: assert property (
    r_reg.state == i2c_id_pkg::st_tx && scl_fall && r_reg.bit_cnt == 4'h8
    |=> r_reg.state == i2c_id_pkg::st_tx_ack && !sda_oe_o)
    else $error("line held after read byte");

  write_all_c: cover property (
    stop && write_done && r_reg.cmd == i2c_id_pkg::cmd_write_everything);
  read_frame_c: cover property (
    r_reg.state == i2c_id_pkg::st_tx_ack && scl_fall);
  fuse_lock_c: cover property (!fuses_locked_o ##1 fuses_locked_o);
  crc_error_c: cover property (crc_error_o);
endmodule

// File: i2c_master_model.sv
// Bus master model that frames traffic for the slave decoder
`timescale 1ns/1ps
module i2c_master_model #(
  parameter int Q = 6
) (
  input wire logic sda_i, // Resolved data line
  output logic scl_o, // Bus clock, master driven
  output logic sda_low_o // Master pulls data low
);
  logic lclk;
  logic run;
  // Link clock of 6 ns, standing still outside frames
  initial begin
    lclk = 1'b0;
    run = 1'b0;
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    #1.7;
    forever begin
      #3;
      lclk = run ? ~lclk : 1'b0;
    end
  end
  task automatic q();
    repeat (Q) @(negedge lclk);
  endtask
  // Start or repeated start, only the master makes it
  task automatic start();
    run = 1'b1;
    sda_low_o = 1'b0;
    q();
    scl_o = 1'b1;
    q();
    sda_low_o = 1'b1;
    q();
    scl_o = 1'b0;
    q();
  endtask
  // Data set while the clock is low, sampled mid high
  task automatic put_bit(input logic b, output logic r);
    sda_low_o = ~b;
    q();
    scl_o = 1'b1;
    q();
    r = sda_i;
    q();
    scl_o = 1'b0;
    q();
  endtask
  task automatic put_byte(input logic [7:0] d, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) put_bit(d[i], r);
    put_bit(1'b1, nack);
  endtask
  task automatic get_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, r);
      d[i] = r;
    end
    put_bit(nack, r);
  endtask
  task automatic stop();
    sda_low_o = 1'b1;
    q();
    scl_o = 1'b1;
    q();
    sda_low_o = 1'b0;
    q();
    q();
    run = 1'b0;
  endtask
endmodule

// File: i2c_id_command_decoder_bench.sv
// Self-checking bench of the identifier command decoder
`timescale 1ns/1ps
`include "i2c_id_regs.svh"
module i2c_id_command_decoder_bench;
  localparam logic [6:0] ADDR = 7'h3A;
  localparam logic [7:0] VER_A = 8'h3C; // Arbitrary value
  localparam logic [7:0] VER_B = 8'hC3; // Arbitrary value
  typedef struct packed {logic err; logic [88:0] regs;} note_t;
  logic core_clk, resetn, scl, sda, sda_drv, sda_oe, m_low, crc_err;
  logic fsel, ssel, locked;
  logic [7:0] bs, gain, rate, faddr;
  logic [15:0] fl, ch, setup, en, sa, sb, act;
  logic [15:0] m_setup, m_en, m_a, m_b;
  logic [7:0] m_gain, m_rate, m_addr;
  logic m_lock;
  logic [88:0] regs;
  note_t notes[$];
  int n_mismatch = 0;
  int n_compared = 0;
  int cycles = 0;
  integer seed = 25542;
  assign sda = ~((sda_oe & ~sda_drv) | m_low);
  assign regs = {setup, gain, en, rate, sa, sb, faddr, locked};
  i2c_id_command_decoder #(.SLAVE_ADDR(ADDR), .VERSION_A(VER_A),
      .VERSION_B(VER_B)) u_i2c_id_command_decoder (
    .core_clk_i(core_clk), .resetn_i(resetn), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_drv), .sda_oe_o(sda_oe), .fuse_program_select_i(fsel),
    .setting_select_input_i(ssel), .bus_state_i(bs), .failures_i(fl),
    .channel_state_i(ch), .bus_setup_o(setup), .dimming_gain_o(gain),
    .dimming_enable_o(en), .dimming_rate_o(rate), .standalone_a_o(sa),
    .standalone_b_o(sb), .fuse_address_o(faddr), .fuses_locked_o(locked),
    .active_setting_o(act), .crc_error_o(crc_err));
  i2c_master_model #(.Q(6)) u_i2c_master_model (
    .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 70000) begin
      n_mismatch++;
      $display("[FAIL] %0t timeout", $time);
      end_sim();
    end
  end
  task automatic fail(input string s);
    n_mismatch++;
    $display("[FAIL] %0t %s", $time, s);
  endtask
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) fail($sformatf("byte %h expected %h", g, e));
  endtask
  task automatic cmp16(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) fail($sformatf("setting %h expected %h", g, e));
  endtask
  task automatic cmp_note(input note_t g, input note_t e);
    n_compared++;
    if (g !== e) fail($sformatf("outputs %h expected %h", g, e));
  endtask
  function automatic logic [88:0] mirror();
    return {m_setup, m_gain, m_en, m_rate, m_a, m_b, m_addr, m_lock};
  endfunction
  function automatic logic [7:0] crc8(input logic [7:0] c,
      input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++)
      x = x[7] ? {x[6:0], 1'b0} ^ `CRC_POLY : {x[6:0], 1'b0};
    return x;
  endfunction
  task automatic wframe(input logic [7:0] a8, input logic [7:0] id,
      input logic [7:0] d[$], input logic crc_on, input logic bad,
      output logic [2:0] nk);
    logic [7:0] c;
    logic n;
    c = crc8(`CRC_INIT, id);
    nk[2] = 1'b0;
    u_i2c_master_model.start();
    u_i2c_master_model.put_byte(a8, nk[0]);
    u_i2c_master_model.put_byte(id, nk[1]);
    foreach (d[i]) begin
      u_i2c_master_model.put_byte(d[i], n);
      nk[2] |= n;
      c = crc8(c, d[i]);
    end
    if (crc_on) u_i2c_master_model.put_byte(c ^ {7'h00, bad}, n);
    u_i2c_master_model.stop();
    repeat (20) @(negedge core_clk);
  endtask
  task automatic wr_ok(input logic [7:0] id, input logic [7:0] d[$],
      input logic crc_on);
    logic [2:0] nk;
    notes.push_back({1'b0, mirror()});
    wframe({ADDR, 1'b0}, id, d, crc_on, 1'b0, nk);
    cmp8({5'h00, nk}, 8'h00);
  endtask
  task automatic rframe(input logic [7:0] id, input logic [7:0] e[$],
      input logic crc_on);
    logic [7:0] c;
    logic [7:0] g;
    logic n;
    c = `CRC_INIT;
    u_i2c_master_model.start();
    u_i2c_master_model.put_byte({ADDR, 1'b0}, n);
    u_i2c_master_model.put_byte(id, n);
    if (crc_on) u_i2c_master_model.put_byte(crc8(`CRC_INIT, id), n);
    u_i2c_master_model.start();
    u_i2c_master_model.put_byte({ADDR, 1'b1}, n);
    cmp8({7'h00, n}, 8'h00);
    foreach (e[i]) begin
      u_i2c_master_model.get_byte(!crc_on && i == e.size() - 1, g);
      cmp8(g, e[i]);
      c = crc8(c, e[i]);
    end
    if (crc_on) begin
      u_i2c_master_model.get_byte(1'b1, g);
      cmp8(g, c);
    end
    u_i2c_master_model.stop();
    repeat (20) @(negedge core_clk);
  endtask
  task automatic fuse(input logic [7:0] id, input logic ok);
    logic [2:0] nk;
    logic [15:0] a;
    logic [15:0] b;
    logic [7:0] f;
    a = 16'($random(seed));
    b = 16'($random(seed));
    f = 8'($random(seed));
    if (ok) begin
      {m_a, m_b, m_addr} = {a, b, f};
      m_lock |= (id == 8'h21);
      notes.push_back({1'b0, mirror()});
    end
    wframe({ADDR, 1'b0}, id, {a[15:8], a[7:0], b[15:8], b[7:0], f}, 1'b1,
        1'b0, nk);
  endtask
  // Any change of the outputs gathered in regs, or an error pulse, takes the oldest note
  initial begin
    logic [88:0] prev;
    note_t e;
    wait (resetn === 1'b1);
    @(negedge core_clk);
    prev = regs;
    forever begin
      @(negedge core_clk);
      if (regs !== prev || crc_err !== 1'b0) begin
        if (notes.size() == 0) fail("unexpected output change");
        else begin
          e = notes.pop_front();
          cmp_note({crc_err, regs}, e);
        end
      end
      prev = regs;
    end
  end
  initial begin
    logic [2:0] nk;
    logic [15:0] v;
    logic [7:0] g;
    logic [7:0] wid[4];
    wid = '{8'h00, 8'h01, 8'h03, 8'h02};
    {resetn, fsel, ssel, bs, fl, ch} = '0;
    {m_setup, m_gain, m_en, m_rate} = {`BUS_SETUP_RST, `GAIN_RST,
        `ENABLE_RST, `RATE_RST};
    {m_a, m_b, m_addr, m_lock} = {`SETTING_A_RST, `SETTING_B_RST,
        `FUSE_ADDR_RST, 1'b0};
    repeat (20) @(negedge core_clk);
    resetn = 1'b1;
    repeat (4) @(negedge core_clk);
    cmp_note({1'b0, regs}, {1'b0, mirror()});
    cmp16(act, 16'h0000);
    $display("test reset done");
    foreach (wid[k]) begin
      v = 16'($random(seed));
      v[0] = 1'b1;
      g = 8'($random(seed));
      case (wid[k])
        8'h00: begin
          m_setup = v;
          wr_ok(8'h00, {v[15:8], v[7:0]}, 1'b1);
        end
        8'h01: begin
          {m_gain, m_en} = {g, v};
          wr_ok(8'h01, {g, v[15:8], v[7:0]}, 1'b1);
        end
        8'h03: begin
          m_rate = g;
          wr_ok(8'h03, {g}, 1'b1);
        end
        default: begin
          {m_setup, m_gain, m_en} = {v, g, ~v};
          wr_ok(8'h02, {v[15:8], v[7:0], g, ~v[15:8], ~v[7:0]},
              1'b1);
        end
      endcase
    end
    $display("test writes done");
    notes.push_back({1'b1, mirror()});
    wframe({ADDR, 1'b0}, 8'h01, {8'h11, 8'h22, 8'h33}, 1'b1, 1'b1,
        nk);
    wframe({ADDR, 1'b0}, 8'h05, {8'h44}, 1'b1, 1'b0, nk);
    cmp8({7'h00, nk[1]}, 8'h01);
    wframe({ADDR ^ 7'h01, 1'b0}, 8'h00, {8'h00, 8'h00}, 1'b1, 1'b0,
        nk);
    cmp8({7'h00, nk[0]}, 8'h01);
    $display("test refusals done");
    @(negedge core_clk);
    {bs, fl, ch} = 40'($random(seed)) ^ {8'h5A, 32'($random(seed))};
    rframe(8'h08, {bs}, 1'b1);
    rframe(8'h09, {fl[15:8], fl[7:0]}, 1'b1);
    rframe(8'h0A, {ch[15:8], ch[7:0], bs, fl[15:8], fl[7:0]}, 1'b1);
    $display("test reads done");
    fuse(8'h20, 1'b0);
    @(negedge core_clk);
    fsel = 1'b1;
    repeat (5) @(negedge core_clk);
    fuse(8'h20, 1'b1);
    rframe(8'h28, {VER_A, VER_B, m_a[15:8], m_a[7:0], m_b[15:8], m_b[7:0],
        m_addr}, 1'b1);
    fuse(8'h21, 1'b1);
    fuse(8'h20, 1'b0);
    ssel = 1'b1;
    repeat (10) @(negedge core_clk);
    cmp16(act, m_b);
    ssel = 1'b0;
    repeat (10) @(negedge core_clk);
    cmp16(act, m_a);
    $display("test fuses done");
    v = 16'($random(seed));
    v[0] = 1'b0;
    m_setup = v;
    wr_ok(8'h00, {v[15:8], v[7:0]}, 1'b1);
    m_rate = ~m_rate;
    wr_ok(8'h03, {m_rate}, 1'b0);
    rframe(8'h08, {bs}, 1'b0);
    cmp8(8'(notes.size()), 8'h00);
    $display("test crc off done");
    end_sim();
  end
endmodule
